// ### design/autodetect_pkg.sv
// Constants and register map of the component autodetect selector
package autodetect_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMITS = 8'h04;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COUNTS = 8'h10;
  localparam logic [7:0] ADDR_DIAG = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_NEW_VARIANT = 0;
  localparam int CTRL_COOLANT_USED = 1;
  localparam int CTRL_REARM = 2;
  localparam int LIM_LEVEL_LSB = 0;
  localparam int LIM_THROTTLE_LSB = 8;
  localparam int OVR_EN_LSB = 0;
  localparam int OVR_RETARDER = 4;
  localparam int OVR_LEVEL = 5;
  localparam int OVR_THROTTLE_LSB = 8;
  localparam int OVR_COOLANT_LSB = 10;
  localparam int DIAG_NO_THROTTLE = 0;
  localparam int DIAG_NO_COOLANT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [7:0] LIMIT_RESET = 8'h32;
  localparam logic [11:0] OVERRIDE_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Start counts and timing
  // ----------------------------------------------------------------
  localparam int CONSEC_STARTS = 5;
  localparam logic [1:0] RETARDER_CONSEC = 2'h3;
  localparam logic [3:0] THROTTLE_COUNTDOWN = 4'hF;
  localparam logic [7:0] FIRST_PERIOD = 8'h18;
  localparam logic [7:0] LONG_PERIOD = 8'h19;
  localparam int WINDOW_S = 30;
  localparam int CLK_HZ = 100_000_000;
  localparam longint WINDOW_CYCLES = longint'(WINDOW_S) * longint'(CLK_HZ);

  // Source codes; bit order of source vectors is analog, J1939, J1587
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_J1939 = 2'h2;
  localparam logic [1:0] SRC_J1587 = 2'h3;

  // Highest priority first: J1939, J1587, analog
  function automatic logic [1:0] pick_source(input logic [2:0] v);
    if (v[1])
      pick_source = SRC_J1939;
    else if (v[2])
      pick_source = SRC_J1587;
    else if (v[0])
      pick_source = SRC_ANALOG;
    else
      pick_source = SRC_NONE;
  endfunction : pick_source

  // Return line one-hot to build level index (level minus one)
  function automatic logic [3:0] decode_level(input logic [7:0] r);
    logic [3:0] idx;
    idx = 4'h8;
    for (int i = 0; i < 8; i++)
    begin
      if (r == (8'h01 << i))
        idx = 4'(i);
    end
    decode_level = idx;
  endfunction : decode_level

endpackage : autodetect_pkg

// ### design/autodetect_selector.sv
// Component autodetect selector with AHB-Lite register slave
`timescale 1ns/10ps

module autodetect_selector #(
  parameter longint WINDOW_CYCLES = autodetect_pkg::WINDOW_CYCLES
) (
  input wire logic hclk,                    // Clock, 100 MHz
  input wire logic hresetn,                 // Power-up reset, active low
  input wire logic hsel,                    // AHB select
  input wire logic [31:0] haddr,            // AHB address
  input wire logic [1:0] htrans,            // AHB transfer type
  input wire logic hwrite,                  // AHB write
  input wire logic [2:0] hsize,             // AHB size
  input wire logic hready,                  // AHB ready in
  input wire logic [31:0] hwdata,           // AHB write data
  output logic [31:0] hrdata,               // AHB read data
  output logic hreadyout,                   // AHB ready out
  output logic hresp,                       // AHB response, always OKAY
  input wire logic engine_start,            // Engine start event pulse
  input wire logic retarder_seen,           // Retarder solenoid sensed
  input wire logic level_seen,              // Fluid level sensor sensed
  input wire logic [2:0] throttle_seen,     // Analog, J1939, J1587 throttle
  input wire logic [2:0] coolant_seen,      // Analog, J1939, J1587 coolant
  input wire logic [7:0] level_return,      // Build level wire return lines
  output logic retarder_enable,             // Retarder in use
  output logic level_diag_enable,           // Fluid level diagnostics allowed
  output logic [1:0] throttle_source,       // Active throttle source
  output logic [1:0] coolant_source,        // Active coolant source
  output logic [2:0] build_level_index,     // Calibration selected
  output logic autodetect_busy              // Some detection still running
);
  import autodetect_pkg::*;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [2:0] ctrl_q;
  logic [7:0] lim_level_q;
  logic [7:0] lim_thr_q;
  logic [11:0] ovr_q;
  logic [1:0] diag_q;
  logic [31:0] rd_mux;

  wire addr_phase = hsel && hready && htrans[1];
  wire wr_now = wr_pend_q;
  wire wr_ctrl = wr_now && (addr_q == ADDR_CTRL);
  wire wr_lim = wr_now && (addr_q == ADDR_LIMITS);
  wire wr_ovr = wr_now && (addr_q == ADDR_OVERRIDE);
  wire wr_diag = wr_now && (addr_q == ADDR_DIAG);
  wire rearm = wr_ctrl && hwdata[CTRL_REARM];
  wire new_variant = ctrl_q[CTRL_NEW_VARIANT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      // Reads take one wait state so a preceding write is always visible
      wr_pend_q <= addr_phase && hwrite;
      rd_pend_q <= addr_phase && !hwrite;
      if (addr_phase)
        addr_q <= {haddr[7:2], 2'b00};
      hreadyout <= !(addr_phase && !hwrite);
      // Only OKAY is ever answered, still from a flop
      hresp <= 1'b0;
      if (rd_pend_q)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= CTRL_RESET;
      lim_level_q <= LIMIT_RESET;
      lim_thr_q <= LIMIT_RESET;
      ovr_q <= OVERRIDE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= {1'b0, hwdata[CTRL_COOLANT_USED:CTRL_NEW_VARIANT]};
      if (wr_lim)
      begin
        lim_level_q <= hwdata[LIM_LEVEL_LSB +: 8];
        lim_thr_q <= hwdata[LIM_THROTTLE_LSB +: 8];
      end
      if (wr_ovr)
        ovr_q <= hwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Detection window
  // ----------------------------------------------------------------
  localparam logic [31:0] WIN_LAST = 32'(WINDOW_CYCLES - 1);
  logic in_win_q;
  logic [31:0] win_cnt_q;
  logic ret_acc_q;
  logic lvl_acc_q;
  logic [2:0] thr_acc_q;
  logic [2:0] cool_acc_q;
  logic [7:0] ret_line_q;
  logic commit_q;
  logic commit2_q;
  logic [7:0] starts_q;

  wire win_end = in_win_q && (win_cnt_q == WIN_LAST);
  wire [7:0] start_n = (starts_q == 8'hFF) ? starts_q : starts_q + 8'h01;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_win_q <= 1'b0;
      win_cnt_q <= 32'h0000_0000;
      ret_acc_q <= 1'b0;
      lvl_acc_q <= 1'b0;
      thr_acc_q <= 3'h0;
      cool_acc_q <= 3'h0;
      ret_line_q <= 8'h00;
      commit_q <= 1'b0;
      commit2_q <= 1'b0;
    end
    else
    begin
      commit_q <= win_end;
      commit2_q <= commit_q;
      if (engine_start && !in_win_q)
      begin
        // A start during an open window is the same start
        in_win_q <= 1'b1;
        win_cnt_q <= 32'h0000_0000;
        ret_acc_q <= retarder_seen;
        lvl_acc_q <= level_seen;
        thr_acc_q <= throttle_seen;
        cool_acc_q <= coolant_seen;
        ret_line_q <= level_return;
      end
      else if (in_win_q)
      begin
        win_cnt_q <= win_cnt_q + 32'h0000_0001;
        in_win_q <= !win_end;
        ret_acc_q <= ret_acc_q | retarder_seen;
        lvl_acc_q <= lvl_acc_q | level_seen;
        thr_acc_q <= thr_acc_q | throttle_seen;
        cool_acc_q <= cool_acc_q | coolant_seen;
        ret_line_q <= ret_line_q | level_return;
      end
    end
  end

  // ----------------------------------------------------------------
  // Start counter, retarder, level sensor, build level
  // ----------------------------------------------------------------
  logic ret_done_q;
  logic ret_present_q;
  logic [1:0] ret_consec_q;
  logic lvl_done_q;
  logic lvl_present_q;
  logic [2:0] level_q;

  wire [7:0] lvl_limit = (lim_level_q > FIRST_PERIOD) ? lim_level_q : FIRST_PERIOD;
  wire [3:0] level_dec = decode_level(ret_line_q);
  wire [1:0] ret_consec_n = ret_acc_q ? ret_consec_q + 2'h1 : 2'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      starts_q <= 8'h00;
      ret_done_q <= 1'b0;
      ret_present_q <= 1'b0;
      ret_consec_q <= 2'h0;
      lvl_done_q <= 1'b0;
      lvl_present_q <= 1'b0;
      level_q <= 3'h0;
    end
    else if (rearm)
    begin
      starts_q <= 8'h00;
      ret_done_q <= 1'b0;
      ret_consec_q <= 2'h0;
      lvl_done_q <= 1'b0;
    end
    else if (commit_q)
    begin
      starts_q <= start_n;
      if (!ret_done_q && new_variant)
      begin
        ret_consec_q <= ret_consec_n;
        if (ret_consec_n == RETARDER_CONSEC)
        begin
          ret_done_q <= 1'b1;
          ret_present_q <= 1'b1;
        end
        else if (start_n >= LONG_PERIOD)
        begin
          ret_done_q <= 1'b1;
          ret_present_q <= 1'b0;
        end
      end
      else if (!ret_done_q && (start_n == FIRST_PERIOD))
      begin
        ret_done_q <= 1'b1;
        ret_present_q <= ret_acc_q;
      end
      if (!lvl_done_q && lvl_acc_q)
      begin
        lvl_done_q <= 1'b1;
        lvl_present_q <= 1'b1;
      end
      else if (!lvl_done_q && (start_n >= lvl_limit))
      begin
        lvl_done_q <= 1'b1;
        lvl_present_q <= 1'b0;
      end
      // Unconnected or shorted level wire keeps the prior calibration
      if ((start_n <= LONG_PERIOD) && !level_dec[3])
        level_q <= level_dec[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Throttle and coolant sources
  // ----------------------------------------------------------------
  logic [2:0] thr_flags;
  logic [2:0] cool_flags;
  logic thr_done_q;
  logic thr_cd_run_q;
  logic [3:0] thr_cd_q;
  logic [1:0] thr_src_q;
  logic cool_done_q;
  logic [1:0] cool_src_q;

  source_tracker #(.N(3), .THRESH(CONSEC_STARTS)) u_thr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(rearm),
    .commit(commit_q && !thr_done_q && new_variant),
    .seen(thr_acc_q),
    .flags(thr_flags)
  );

  source_tracker #(.N(3), .THRESH(CONSEC_STARTS)) u_cool (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(rearm),
    .commit(commit_q && !cool_done_q),
    .seen(cool_acc_q),
    .flags(cool_flags)
  );

  wire [1:0] thr_best = (|thr_flags) ? pick_source(thr_flags) : pick_source(thr_acc_q);
  wire [1:0] cool_best = (|cool_flags) ? pick_source(cool_flags) : pick_source(cool_acc_q);
  wire [7:0] cool_end = new_variant ? LONG_PERIOD : FIRST_PERIOD;
  wire thr_datalink = thr_acc_q[1] || thr_acc_q[2];
  wire old_thr_limit = (starts_q >= FIRST_PERIOD) && (starts_q >= lim_thr_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      thr_done_q <= 1'b0;
      thr_cd_run_q <= 1'b0;
      thr_cd_q <= 4'h0;
      thr_src_q <= SRC_NONE;
      cool_done_q <= 1'b0;
      cool_src_q <= SRC_NONE;
    end
    else if (rearm)
    begin
      thr_done_q <= 1'b0;
      thr_cd_run_q <= 1'b0;
      thr_cd_q <= 4'h0;
      cool_done_q <= 1'b0;
    end
    else if (commit2_q)
    begin
      if (!thr_done_q && new_variant)
      begin
        thr_src_q <= thr_best;
        if (thr_cd_run_q && (thr_cd_q == 4'h1))
        begin
          thr_done_q <= 1'b1;
          thr_src_q <= pick_source(thr_flags);
        end
        if (thr_cd_run_q)
          thr_cd_q <= thr_cd_q - 4'h1;
        else if (|thr_flags)
        begin
          // Otherwise no limit on the number of starts
          thr_cd_run_q <= 1'b1;
          thr_cd_q <= THROTTLE_COUNTDOWN;
        end
      end
      else if (!thr_done_q)
      begin
        if (thr_datalink || thr_acc_q[0])
        begin
          thr_done_q <= 1'b1;
          thr_src_q <= pick_source(thr_acc_q);
        end
        else if (old_thr_limit)
        begin
          thr_done_q <= 1'b1;
          thr_src_q <= SRC_NONE;
        end
      end
      if (!cool_done_q)
      begin
        cool_src_q <= cool_best;
        if (starts_q >= cool_end)
          cool_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic codes, sticky, write one to clear
  // ----------------------------------------------------------------
  wire set_26_00 = commit2_q && !thr_done_q && !new_variant && (thr_acc_q == 3'h0);
  wire set_26_11 = commit2_q && !cool_done_q && (starts_q >= cool_end) && (cool_best == SRC_NONE)
                   && ctrl_q[CTRL_COOLANT_USED];
  wire [1:0] diag_set = {set_26_11, set_26_00};
  wire [1:0] diag_clr = wr_diag ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      diag_q <= 2'h0;
    else
      diag_q <= (diag_q & ~diag_clr) | diag_set;
  end

  // ----------------------------------------------------------------
  // Effective settings, service overrides win
  // ----------------------------------------------------------------
  wire eff_ret = ovr_q[OVR_EN_LSB] ? ovr_q[OVR_RETARDER] : ret_present_q;
  wire eff_lvl = ovr_q[OVR_EN_LSB + 1] ? ovr_q[OVR_LEVEL] : lvl_present_q;
  wire [1:0] eff_thr = ovr_q[OVR_EN_LSB + 2] ? ovr_q[OVR_THROTTLE_LSB +: 2] : thr_src_q;
  wire [1:0] eff_cool = ovr_q[OVR_EN_LSB + 3] ? ovr_q[OVR_COOLANT_LSB +: 2] : cool_src_q;
  wire busy = !(ret_done_q && lvl_done_q && thr_done_q && cool_done_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      retarder_enable <= 1'b0;
      level_diag_enable <= 1'b0;
      throttle_source <= SRC_NONE;
      coolant_source <= SRC_NONE;
      build_level_index <= 3'h0;
      autodetect_busy <= 1'b1;
    end
    else
    begin
      retarder_enable <= eff_ret;
      level_diag_enable <= eff_lvl;
      throttle_source <= eff_thr;
      coolant_source <= eff_cool;
      build_level_index <= level_q;
      autodetect_busy <= busy;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_status = {16'h0000, 4'h0, cool_done_q, thr_done_q, lvl_done_q, ret_done_q,
                           cool_src_q, thr_src_q, 2'b00, lvl_present_q, ret_present_q};
  wire [31:0] rd_counts = {8'h00, thr_cd_run_q, 2'b00, level_dec[3], 1'b0, level_q,
                           4'h0, thr_cd_q, starts_q};

  assign rd_mux = (addr_q == ADDR_CTRL) ? {29'h0, 1'b0, ctrl_q[1:0]} :
                  (addr_q == ADDR_LIMITS) ? {16'h0000, lim_thr_q, lim_level_q} :
                  (addr_q == ADDR_OVERRIDE) ? {20'h00000, ovr_q} :
                  (addr_q == ADDR_STATUS) ? rd_status :
                  (addr_q == ADDR_COUNTS) ? rd_counts :
                  (addr_q == ADDR_DIAG) ? {30'h0, diag_q} : 32'h0000_0000;

endmodule : autodetect_selector

// ### design/source_tracker.sv
// Per-source consecutive-detection counters and confidence flags
`timescale 1ns/10ps
module source_tracker #(
  parameter int N = 3,
  parameter int THRESH = autodetect_pkg::CONSEC_STARTS
) (
  input wire logic hclk,           // Clock
  input wire logic hresetn,        // Async reset, active low
  input wire logic clear,          // Re-arm, clears counts and flags
  input wire logic commit,         // One engine start completed
  input wire logic [N-1:0] seen,   // Sources seen during the window
  output logic [N-1:0] flags       // Confidence flags
);
  import autodetect_pkg::*;

  logic [2:0] cnt_q [N];

  for (genvar g = 0; g < N; g++)
  begin : g_src
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        cnt_q[g] <= 3'h0;
        flags[g] <= 1'b0;
      end
      else if (clear)
      begin
        cnt_q[g] <= 3'h0;
        flags[g] <= 1'b0;
      end
      else if (commit)
      begin
        // Streak breaks on a start without detection
        cnt_q[g] <= seen[g] ? ((cnt_q[g] == 3'(THRESH)) ? cnt_q[g] : cnt_q[g] + 3'h1) : 3'h0;
        if (seen[g] && (cnt_q[g] + 3'h1 >= 3'(THRESH)))
          flags[g] <= 1'b1;
      end
    end
  end

endmodule : source_tracker

// ### verif/autodetect_selector_monitor.sv
// Checker of bus timing and result stability for the autodetect selector
`timescale 1ns/10ps
module autodetect_selector_monitor #(
  parameter longint WINDOW_CYCLES = 20
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic engine_start, // Start
  input wire logic retarder_enable, // Result
  input wire logic level_diag_enable, // Result
  input wire logic [1:0] throttle_source, // Result
  input wire logic [1:0] coolant_source, // Result
  input wire logic [2:0] build_level_index, // Result
  input wire logic autodetect_busy // Busy
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  wire [9:0] res = {retarder_enable, level_diag_enable, throttle_source, coolant_source, build_level_index,
    autodetect_busy};
  // Cycles since the last start or write; results may only move shortly after one
  longint quiet_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quiet_q <= 0;
    else if (engine_start || (take && hwrite))
      quiet_q <= 0;
    else if (quiet_q < WINDOW_CYCLES + 9)
      quiet_q <= quiet_q + 1;
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("stall without read");
  a_rdata_holds: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved");
  a_reset_state: assert property ($rose(hresetn) |-> hreadyout && autodetect_busy && res[9:1] == 9'h000)
    else $error("reset state wrong");
  a_results_hold: assert property (quiet_q >= WINDOW_CYCLES + 8 |-> $stable(res))
    else $error("result moved while quiet");
  a_window_first: assert property (engine_start && quiet_q > WINDOW_CYCLES + 8 |=> $stable(res) [*8])
    else $error("result moved inside window");
  c_read: cover property (take && !hwrite);
  c_ret_on: cover property ($rose(retarder_enable));
  c_level_on: cover property ($rose(level_diag_enable));
endmodule : autodetect_selector_monitor

bind autodetect_selector autodetect_selector_monitor #(.WINDOW_CYCLES(WINDOW_CYCLES)) mon (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .engine_start, .retarder_enable,
  .level_diag_enable, .throttle_source, .coolant_source, .build_level_index, .autodetect_busy);

// ### verif/test_component_autodetect_selector.sv
// Self-checking bench for the component autodetect selector
`timescale 1ns/10ps
module test_component_autodetect_selector;
  import autodetect_pkg::*;
  localparam int W = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] pat = 16'h0;
  logic [31:0] hrdata, rd, r;
  logic [15:0] lines, p;
  logic [7:0] lr;
  logic [1:0] thr_src, cool_src;
  logic [2:0] lvl_idx;
  logic hready, hreadyout, hresp, engine_start, ret_en, lvl_en, busy;
  int errors = 0;
  int num_checks = 0;
  int seed = 32'h0505;
  int starts, rc, r_done, r_on, l_done, l_on, t_down, t_done, t_src, t_flag, c_flag, c_done, c_src, lvl;
  int t_cnt[3];
  int c_cnt[3];

  assign hready = hreadyout;
  autodetect_selector #(.WINDOW_CYCLES(W)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .engine_start, .retarder_seen(lines[15]),
    .level_seen(lines[14]), .throttle_seen(lines[13:11]), .coolant_seen(lines[10:8]), .level_return(lines[7:0]),
    .retarder_enable(ret_en), .level_diag_enable(lvl_en), .throttle_source(thr_src), .coolant_source(cool_src),
    .build_level_index(lvl_idx), .autodetect_busy(busy));
  vehicle_model #(.W(W)) car (.hclk, .go, .pat, .engine_start, .lines);

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do
      @(posedge hclk);
    while (!hready && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge hclk);
    while (!hready && ++n < 50);
    rd = hrdata;
    chk("bus ready", 32'h0, 32'(n >= 50));
  endtask : bus

  task automatic start(input logic [15:0] q);
    @(posedge hclk);
    pat <= q;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (W + 8) @(posedge hclk);
  endtask : start

  function automatic int best(input int v);
    return v[1] ? 2 : (v[2] ? 3 : v[0]);
  endfunction : best

  task automatic mdl(input logic [15:0] q);
    starts++;
    if (!r_done)
    begin
      rc = q[15] ? rc + 1 : 0;
      r_on = rc >= 3;
      r_done = r_on || starts >= 25;
    end
    if (!l_done)
    begin
      l_on = q[14];
      l_done = l_on || starts >= 24;
    end
    for (int i = 0; i < 3; i++)
    begin
      t_cnt[i] = q[11 + i] ? t_cnt[i] + 1 : 0;
      c_cnt[i] = q[8 + i] ? c_cnt[i] + 1 : 0;
      if (t_cnt[i] >= 5 && !t_done)
        t_flag |= 1 << i;
      if (c_cnt[i] >= 5 && !c_done)
        c_flag |= 1 << i;
    end
    if (!t_done)
    begin
      if (t_down > 0)
      begin
        t_down--;
        t_done = t_down == 0;
      end
      else if (t_flag != 0)
        t_down = 15;
      t_src = t_flag != 0 ? best(t_flag) : best(q[13:11]);
    end
    if (!c_done)
    begin
      c_src = c_flag != 0 ? best(c_flag) : best(q[10:8]);
      c_done = starts >= 25;
    end
    for (int i = 0; i < 8; i++)
      if (starts <= 25 && q[i])
        lvl = i;
  endtask : mdl

  task automatic cmp_all();
    chk("retarder", r_on, ret_en);
    chk("level", l_on, lvl_en);
    chk("throttle", t_src, thr_src);
    chk("coolant", c_src, cool_src);
    chk("build level", lvl, lvl_idx);
    chk("busy", 32'(!(r_done && l_done && t_done && c_done)), busy);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", {c_done[0], t_done[0], l_done[0], r_done[0], c_src[1:0], t_src[1:0], 2'h0, l_on[0], r_on[0]}, rd);
  endtask : cmp_all

  task automatic test_done();
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Work is near 1800 cycles; the limit of 20000 cycles leaves wide margin
  initial
  begin
    #200000;
    errors++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    for (int a = 0; a < 7; a++)
    begin
      bus(1'b0, 8'(4 * a), 32'h0);
      // Counts show the level wire invalid until a start has seen a return line
      chk("register", a == 0 ? 32'h1 : (a == 1 ? 32'h3232 : (a == 4 ? 32'h0010_0000 : 32'h0)), rd);
    end
    bus(1'b1, ADDR_LIMITS, 32'h3218);
    lr = 8'h01 << ($random(seed) & 7);
    for (int k = 1; k <= 27; k++)
    begin
      r = $random(seed);
      p = {r[7] | r[8], 1'(k > 24), r[1] | r[4], r[2], 1'b1, 1'b1, r[5], r[6], lr};
      start(p);
      mdl(p);
      cmp_all();
    end
    bus(1'b1, ADDR_OVERRIDE, 32'h091F);
    bus(1'b0, ADDR_OVERRIDE, 32'h0);
    chk("override", 32'h091F, rd);
    chk("override out", 32'h26, {ret_en, lvl_en, thr_src, cool_src});
    bus(1'b1, ADDR_OVERRIDE, 32'h0);
    repeat (4) @(posedge hclk);
    cmp_all();
    bus(1'b1, ADDR_CTRL, 32'h5);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("control", 32'h1, rd);
    start({2'b01, 6'b001100, lr});
    chk("level after rearm", 32'h1, lvl_en);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h2);
    for (int k = 1; k <= 24; k++)
    begin
      start({1'(k == 24), 15'h0080});
      if (k == 1 || k == 24)
      begin
        bus(1'b0, ADDR_DIAG, 32'h0);
        chk("diag", k == 1 ? 32'h1 : 32'h3, rd);
      end
    end
    chk("old retarder", 32'h1, ret_en);
    chk("old sources", 32'h0, {thr_src, cool_src});
    chk("level index", 32'h7, lvl_idx);
    bus(1'b1, ADDR_DIAG, 32'h3);
    bus(1'b0, ADDR_DIAG, 32'h0);
    chk("diag cleared", 32'h0, rd);
    test_done();
  end
endmodule : test_component_autodetect_selector

// ### verif/vehicle_model.sv
// Vehicle side model: engine starts and sensor lines
`timescale 1ns/10ps
module vehicle_model #(
  parameter int W = 20
) (
  input wire logic hclk, // Clock
  input wire logic go, // Start request
  input wire logic [15:0] pat, // Lines during window
  output logic engine_start, // Start pulse
  output logic [15:0] lines // Retarder, level, throttle, coolant, return
);
  int cnt = 0;
  initial
  begin
    engine_start = 1'b0;
    lines = 16'h0000;
  end
  // Lines toggle outside the window, so sampling there shows up
  always @(posedge hclk)
  begin
    engine_start <= go && cnt == 0;
    cnt <= (go && cnt == 0) ? W + 2 : (cnt > 0 ? cnt - 1 : 0);
    lines <= (go || cnt > 0) ? pat : ~lines;
  end
endmodule : vehicle_model
